/* File: hw/ims_pkg.sv */
// Constants for the interrupt message store table
package ims_pkg;
    // ---------------------------------------------------------------
    // Entry layout
    // ---------------------------------------------------------------
    localparam int unsigned ENTRY_BYTES     = 16;
    localparam int unsigned ENTRY_SHIFT     = 4;
    localparam logic [3:0]  OFS_ADDR_LO     = 4'h0;
    localparam logic [3:0]  OFS_ADDR_HI     = 4'h4;
    localparam logic [3:0]  OFS_DATA        = 4'h8;
    localparam logic [3:0]  OFS_CTRL        = 4'hc;
    // ---------------------------------------------------------------
    // Control word fields
    // ---------------------------------------------------------------
    localparam int unsigned CTL_MASK        = 0;
    localparam int unsigned CTL_PEND        = 1;
    localparam int unsigned CTL_IGNORE      = 2;
    localparam int unsigned CTL_PASID_EN    = 3;
    localparam int unsigned CTL_PASID_LSB   = 12;
    localparam int unsigned PASID_W         = 20;
    // ---------------------------------------------------------------
    // Message address reset and filter
    // ---------------------------------------------------------------
    localparam logic [63:0] ADDR_RESET      = 64'h0000_0000_fee0_0000;
    localparam int unsigned ADDR_FILT_LSB   = 20;
    localparam logic [43:0] ADDR_FILT_VAL   = 44'h0000_0000_fee;
    localparam int unsigned LEGACY_LIMIT    = 2048;
endpackage

/* File: hw/ims_word_ram.sv */
`timescale 1ns/1ps
// Small word memory with registered read data for table storage
module ims_word_ram #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 64
) (
    input  wire logic                     clk,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [WIDTH-1:0]         wdata,
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic      [WIDTH-1:0]         rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

/* File: hw/interrupt_message_store_table.sv */
// Interrupt message store table: entries, mask/pending/ignore, message writes
`timescale 1ns/1ps
module interrupt_message_store_table #(
    parameter bit          STORAGE_SUPPORT = 1'b1,
    parameter int unsigned ENTRIES         = 64
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    // Register access: byte offset relative to table base, 32-bit words
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    input  wire logic [$clog2(ENTRIES)+3:0]   reg_addr,
    input  wire logic [31:0]                  reg_wdata,
    output logic      [31:0]                  reg_rdata,
    output logic                              reg_rvalid,
    // Interrupt raise request from the device's engines
    input  wire logic                         raise_req,
    input  wire logic [$clog2(ENTRIES)-1:0]   raise_index,
    input  wire logic                         raise_is_completion,
    input  wire logic                         raise_pasid_en,
    input  wire logic [19:0]                  raise_pasid,
    output logic                              raise_ready,
    output logic                              raise_reject,
    // Memory write toward the host interrupt fabric
    output logic                              msg_valid,
    output logic      [63:0]                  msg_addr,
    output logic      [31:0]                  msg_data,
    input  wire logic                         msg_ready
);
    localparam int unsigned IW = $clog2(ENTRIES);

    // Index bits are cut straight from the offset, so only powers of two decode cleanly
    if (ENTRIES < 2 || (ENTRIES & (ENTRIES - 1)) != 0) begin : g_bad_entries
        $error("ENTRIES must be a power of two, at least 2");
    end

    // ---------------------------------------------------------------
    // State machine
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_SEND  = 2'b10
    } send_state_e;

    send_state_e     state;
    send_state_e     next_state;
    logic [IW-1:0]   send_idx;

    // Per-entry address and control held in flops (address needs a reset)
    logic [61:0]     addr_q   [ENTRIES];
    logic            mask_q   [ENTRIES];
    logic            pend_q   [ENTRIES];
    logic            ign_q    [ENTRIES];
    logic            pen_q    [ENTRIES];
    logic [19:0]     pasid_q  [ENTRIES];

    // ---------------------------------------------------------------
    // Register decode
    // ---------------------------------------------------------------
    wire  [IW-1:0]   w_idx     = reg_addr[IW+3:4];
    wire  [3:0]      w_ofs     = reg_addr[3:0];
    wire             wr_on     = reg_wr && STORAGE_SUPPORT;
    wire             wr_alo    = wr_on && (w_ofs == ims_pkg::OFS_ADDR_LO);
    wire             wr_ahi    = wr_on && (w_ofs == ims_pkg::OFS_ADDR_HI);
    wire             wr_data   = wr_on && (w_ofs == ims_pkg::OFS_DATA);
    wire             wr_ctrl   = wr_on && (w_ofs == ims_pkg::OFS_CTRL);
    // 32-bit writes: low half carries bits 31:20 of the filter, high half the rest
    wire             lo_ok     = reg_wdata[31:20] == ims_pkg::ADDR_FILT_VAL[11:0];
    wire             hi_ok     = reg_wdata == ims_pkg::ADDR_FILT_VAL[43:12];
    wire             unmask_fire = wr_ctrl && !reg_wdata[ims_pkg::CTL_MASK]
                                   && mask_q[w_idx] && pend_q[w_idx];

    // ---------------------------------------------------------------
    // Raise handling
    // ---------------------------------------------------------------
    wire             r_ign     = raise_is_completion && ign_q[raise_index];
    wire             pasid_bad = raise_is_completion &&
                                 ((pen_q[raise_index] != raise_pasid_en) ||
                                  (pen_q[raise_index] &&
                                   pasid_q[raise_index] != raise_pasid));
    wire             raise_go  = raise_req && raise_ready && STORAGE_SUPPORT;
    wire             r_take    = raise_go && !r_ign && !pasid_bad;
    wire             r_masked  = mask_q[raise_index];
    wire             r_send    = r_take && !r_masked && state == ST_IDLE;

    // Message data read port
    logic [31:0]     ram_rdata;
    wire  [IW-1:0]   ram_raddr = (state == ST_IDLE && unmask_fire) ? w_idx :
                                 (state == ST_IDLE && r_send) ? raise_index :
                                 reg_addr[IW+3:4];

    ims_word_ram #(
        .WIDTH (32),
        .DEPTH (ENTRIES)
    ) u_data_ram (
        .clk   (clk),
        .we    (wr_data),
        .waddr (w_idx),
        .wdata (reg_wdata),
        .raddr (ram_raddr),
        .rdata (ram_rdata)
    );

    // An unmask write outranks a raise in the same cycle; a colliding unmasked
    // raise is lost, so engines must not raise while software unmasks
    wire start_unmask = (state == ST_IDLE) && unmask_fire;
    wire start_raise  = (state == ST_IDLE) && !unmask_fire && r_send;
    wire sent         = (state == ST_SEND) && msg_ready;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_unmask || start_raise) begin
                    next_state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                next_state = ST_SEND;
            end
            ST_SEND: begin
                if (msg_ready) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state    <= ST_IDLE;
            send_idx <= '0;
        end else begin
            state <= next_state;
            if (start_unmask) begin
                send_idx <= w_idx;
            end else if (start_raise) begin
                send_idx <= raise_index;
            end
        end
    end

    // ---------------------------------------------------------------
    // Entry storage
    // ---------------------------------------------------------------
    for (genvar e = 0; e < ENTRIES; e++) begin : g_entry
        wire hit   = w_idx == IW'(e);
        wire rhit  = raise_index == IW'(e);
        // Pending from a masked raise; a raise in the same cycle as a send wins
        wire p_set = r_take && rhit && (r_masked || state != ST_IDLE);
        wire p_clr = sent && send_idx == IW'(e);
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                addr_q[e]  <= ims_pkg::ADDR_RESET[63:2];
                mask_q[e]  <= 1'b1;
                pend_q[e]  <= 1'b0;
                ign_q[e]   <= 1'b0;
                pen_q[e]   <= 1'b0;
                pasid_q[e] <= '0;
            end else begin
                if (wr_alo && hit && lo_ok) begin
                    addr_q[e][29:0] <= reg_wdata[31:2];
                end
                if (wr_ahi && hit && hi_ok) begin
                    addr_q[e][61:30] <= reg_wdata;
                end
                if (wr_ctrl && hit) begin
                    mask_q[e]  <= reg_wdata[ims_pkg::CTL_MASK];
                    ign_q[e]   <= reg_wdata[ims_pkg::CTL_IGNORE];
                    pen_q[e]   <= reg_wdata[ims_pkg::CTL_PASID_EN];
                    pasid_q[e] <= reg_wdata[31:ims_pkg::CTL_PASID_LSB];
                end
                if (p_set) begin
                    pend_q[e] <= 1'b1;
                end else if (p_clr) begin
                    pend_q[e] <= 1'b0;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Read path, message port, raise answers
    // ---------------------------------------------------------------
    logic [3:0]    rd_ofs;
    logic [IW-1:0] rd_idx;
    logic          rd_pend;
    wire  [31:0]   ctrl_word = {pasid_q[rd_idx], 8'h00, pen_q[rd_idx],
                                ign_q[rd_idx], pend_q[rd_idx], mask_q[rd_idx]};
    wire  [63:0]   full_addr = {addr_q[rd_idx], 2'b00};
    wire  [31:0]   rd_word   = !STORAGE_SUPPORT ? 32'h0000_0000 :
                               (rd_ofs == ims_pkg::OFS_ADDR_LO) ? full_addr[31:0] :
                               (rd_ofs == ims_pkg::OFS_ADDR_HI) ? full_addr[63:32] :
                               (rd_ofs == ims_pkg::OFS_DATA) ? ram_rdata :
                               (rd_ofs == ims_pkg::OFS_CTRL) ? ctrl_word : 32'h0000_0000;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_pend      <= 1'b0;
            rd_ofs       <= 4'h0;
            rd_idx       <= '0;
            reg_rdata    <= 32'h0000_0000;
            reg_rvalid   <= 1'b0;
        end else begin
            // Read waits one cycle for the memory; a send fetch steals the port
            rd_pend    <= reg_rd && !(start_unmask || start_raise);
            rd_ofs     <= w_ofs;
            rd_idx     <= w_idx;
            reg_rvalid <= rd_pend;
            if (rd_pend) begin
                reg_rdata <= rd_word;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msg_valid    <= 1'b0;
            msg_addr     <= 64'h0000_0000_0000_0000;
            msg_data     <= 32'h0000_0000;
            raise_ready  <= 1'b0;
            raise_reject <= 1'b0;
        end else begin
            if (state == ST_FETCH) begin
                msg_valid <= 1'b1;
                msg_addr  <= {addr_q[send_idx], 2'b00};
                msg_data  <= ram_rdata;
            end else if (sent) begin
                msg_valid <= 1'b0;
            end
            // Ready follows the next state so no raise is taken mid-send
            raise_ready  <= STORAGE_SUPPORT && next_state == ST_IDLE;
            raise_reject <= raise_go && pasid_bad;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_pend_clear_on_send: assert property (@(posedge clk) disable iff (rst)
        sent |=> !pend_q[send_idx] || $past(r_take))
        else $error("pending not cleared after send");
    a_unmask_sends: assert property (@(posedge clk) disable iff (rst)
        start_unmask |-> ##2 (msg_valid && msg_addr == {addr_q[$past(w_idx, 2)], 2'b00}))
        else $error("unmask with pending did not send");
    a_masked_sets_pend: assert property (@(posedge clk) disable iff (rst)
        (r_take && r_masked) |=> pend_q[$past(raise_index)])
        else $error("masked raise did not set pending");
    a_ignore_no_send: assert property (@(posedge clk) disable iff (rst)
        (raise_go && r_ign && !unmask_fire && state == ST_IDLE) |=> state == ST_IDLE)
        else $error("ignored completion started a send");
    a_raise_sends: assert property (@(posedge clk) disable iff (rst)
        start_raise |-> ##2 (msg_valid && msg_addr == {addr_q[$past(raise_index, 2)], 2'b00}))
        else $error("raise did not issue message write");
    a_msg_holds: assert property (@(posedge clk) disable iff (rst)
        (msg_valid && !msg_ready) |=> msg_valid && $stable(msg_data) && $stable(msg_addr))
        else $error("message dropped before accept");
    a_addr_filter: assert property (@(posedge clk) disable iff (rst)
        (wr_ahi && !hi_ok) |=> addr_q[$past(w_idx)] == $past(addr_q[w_idx]))
        else $error("filtered address write stored");
    a_pasid_reject: assert property (@(posedge clk) disable iff (rst)
        (raise_go && raise_is_completion && pen_q[raise_index] != raise_pasid_en)
        |=> raise_reject)
        else $error("pasid enable mismatch not rejected");
    a_addr_filter_lo: assert property (@(posedge clk) disable iff (rst)
        (wr_alo && !lo_ok) |=> addr_q[$past(w_idx)] == $past(addr_q[w_idx]))
        else $error("filtered low address write stored");
    a_ignore_no_pend: assert property (@(posedge clk) disable iff (rst)
        (raise_go && r_ign) |=> pend_q[$past(raise_index)] == $past(pend_q[raise_index]))
        else $error("ignored completion changed pending");
    a_reject_no_send: assert property (@(posedge clk) disable iff (rst)
        (raise_go && pasid_bad && !unmask_fire) |=> state == ST_IDLE)
        else $error("rejected raise started a send");
    a_pend_sw_ro: assert property (@(posedge clk) disable iff (rst)
        (wr_ctrl && !r_take && !sent) |=> pend_q[$past(w_idx)] == $past(pend_q[w_idx]))
        else $error("software write changed pending");
    a_ready_low_busy: assert property (@(posedge clk) disable iff (rst)
        (state != ST_IDLE) |-> !raise_ready)
        else $error("raise accepted while a send is in flight");
    a_read_answer: assert property (@(posedge clk) disable iff (rst)
        (reg_rd && !start_unmask && !start_raise) |-> ##2 reg_rvalid)
        else $error("register read not answered");
    c_masked_raise: cover property (@(posedge clk) r_take && r_masked);
    c_ignored_raise: cover property (@(posedge clk) raise_go && r_ign);
    c_pasid_reject: cover property (@(posedge clk) raise_go && pasid_bad);
    c_unmask_send:  cover property (@(posedge clk) start_unmask);
    c_direct_send:  cover property (@(posedge clk) sent);
endmodule

/* File: tb/fabric_model.sv */
// Host interrupt fabric model: accepts message writes after a chosen stall
`timescale 1ns/1ps
module fabric_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        msg_valid,
    input  wire logic [63:0] msg_addr,
    input  wire logic [31:0] msg_data,
    input  wire logic [3:0]  stall,
    output logic             msg_ready,
    output int               got,
    output logic      [63:0] last_addr,
    output logic      [31:0] last_data
);
    logic [3:0] cnt;

    // Ready only rises while a write is offered, never ahead of it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt       <= 4'h0;
            msg_ready <= 1'b0;
            got       <= 0;
            last_addr <= 64'h0;
            last_data <= 32'h0;
        end else if (msg_valid && msg_ready) begin
            got       <= got + 1;
            last_addr <= msg_addr;
            last_data <= msg_data;
            msg_ready <= 1'b0;
            cnt       <= 4'h0;
        end else if (msg_valid) begin
            cnt       <= cnt + 4'h1;
            msg_ready <= (cnt + 4'h1) >= stall;
        end
    end
endmodule

/* File: tb/interrupt_message_store_table_tb.sv */
// Self-checking bench for the interrupt message store table
`timescale 1ns/1ps
module interrupt_message_store_table_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    logic [5:0]  reg_addr = 6'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata, rdata_np;
    logic        reg_rvalid, raise_ready, raise_reject;
    logic        raise_req = 1'b0, raise_is_completion = 1'b0, raise_pasid_en = 1'b0;
    logic [1:0]  raise_index = 2'h0;
    logic [19:0] raise_pasid = 20'h0;
    logic        msg_valid, msg_ready, rej;
    logic [63:0] msg_addr, last_addr;
    logic [31:0] msg_data, last_data;
    logic [3:0]  stall = 4'h0;
    int          got, exp_msgs = 0, num_errors = 0, cmp_count = 0, cycles = 0;

    interrupt_message_store_table #(.STORAGE_SUPPORT(1'b1), .ENTRIES(4)) i_dut (
        .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .raise_req(raise_req), .raise_index(raise_index),
        .raise_is_completion(raise_is_completion), .raise_pasid_en(raise_pasid_en),
        .raise_pasid(raise_pasid), .raise_ready(raise_ready), .raise_reject(raise_reject),
        .msg_valid(msg_valid), .msg_addr(msg_addr), .msg_data(msg_data),
        .msg_ready(msg_ready));

    // Build without storage support sees the same traffic and must stay blank
    interrupt_message_store_table #(.STORAGE_SUPPORT(1'b0), .ENTRIES(4)) i_absent (
        .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(rdata_np), .reg_rvalid(),
        .raise_req(raise_req), .raise_index(raise_index),
        .raise_is_completion(raise_is_completion), .raise_pasid_en(raise_pasid_en),
        .raise_pasid(raise_pasid), .raise_ready(), .raise_reject(),
        .msg_valid(), .msg_addr(), .msg_data(), .msg_ready(1'b1));

    fabric_model i_fabric (
        .clk(clk), .rst(rst), .msg_valid(msg_valid), .msg_addr(msg_addr),
        .msg_data(msg_data), .stall(stall), .msg_ready(msg_ready), .got(got),
        .last_addr(last_addr), .last_data(last_data));

    always #4 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end

    // ---------------------------------------------------------------
    // Access tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        int i;
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        for (i = 0; i < 8 && reg_rvalid !== 1'b1; i++) @(negedge clk);
        check(reg_rvalid, 1'b1);
        check(reg_rdata, exp);
        check(rdata_np, 64'h0);
    endtask

    // Raise one request and note any reject pulse that follows it
    task automatic raise(input logic [1:0] idx, input logic comp, input logic pen,
                         input logic [19:0] pid);
        int i;
        @(negedge clk);
        for (i = 0; i < 20 && raise_ready !== 1'b1; i++) @(negedge clk);
        raise_req = 1'b1;
        raise_index = idx;
        raise_is_completion = comp;
        raise_pasid_en = pen;
        raise_pasid = pid;
        @(negedge clk);
        raise_req = 1'b0;
        // The reject pulse stands only in the cycle after the request is taken
        rej = raise_reject;
        repeat (2) @(negedge clk);
    endtask

    task automatic wait_msg(input logic [63:0] a, input logic [31:0] d);
        int i;
        exp_msgs++;
        for (i = 0; i < 40 && got != exp_msgs; i++) @(negedge clk);
        check(got, exp_msgs);
        check(last_addr, a);
        check(last_data, d);
        check(raise_ready, 1'b1);
    endtask

    task automatic no_msg;
        repeat (8) @(negedge clk);
        check(got, exp_msgs);
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        rd(6'h30, 32'hfee0_0000);
        rd(6'h34, 32'h0);
        rd(6'h3c, 32'h1);
        $display("test reset done");
        wr(6'h10, 32'h1234_5678);
        rd(6'h10, 32'hfee0_0000);
        wr(6'h14, 32'h1);
        rd(6'h14, 32'h0);
        wr(6'h10, 32'hfee0_1237);
        rd(6'h10, 32'hfee0_1234);
        wr(6'h18, 32'ha5a5_0001);
        rd(6'h18, 32'ha5a5_0001);
        rd(6'h00, 32'hfee0_0000);
        $display("test layout done");
        stall = 4'h3;
        raise(2'h1, 1'b1, 1'b0, 20'h0);
        no_msg();
        rd(6'h1c, 32'h3);
        wr(6'h1c, 32'h2);
        wait_msg(64'hfee0_1234, 32'ha5a5_0001);
        rd(6'h1c, 32'h0);
        stall = 4'h0;
        raise(2'h1, 1'b1, 1'b0, 20'h0);
        wait_msg(64'hfee0_1234, 32'ha5a5_0001);
        $display("test mask done");
        wr(6'h1c, 32'h4);
        raise(2'h1, 1'b1, 1'b0, 20'h0);
        no_msg();
        rd(6'h1c, 32'h4);
        raise(2'h1, 1'b0, 1'b0, 20'h0);
        wait_msg(64'hfee0_1234, 32'ha5a5_0001);
        wr(6'h1c, 32'h5);
        raise(2'h1, 1'b1, 1'b0, 20'h0);
        rd(6'h1c, 32'h5);
        raise(2'h1, 1'b0, 1'b0, 20'h0);
        rd(6'h1c, 32'h7);
        wr(6'h1c, 32'h4);
        wait_msg(64'hfee0_1234, 32'ha5a5_0001);
        $display("test ignore done");
        wr(6'h28, 32'h22);
        wr(6'h2c, 32'h1234_5008);
        raise(2'h2, 1'b1, 1'b0, 20'h12345);
        check(rej, 1'b1);
        raise(2'h2, 1'b1, 1'b1, 20'h12346);
        check(rej, 1'b1);
        no_msg();
        raise(2'h2, 1'b1, 1'b1, 20'h12345);
        check(rej, 1'b0);
        wait_msg(64'hfee0_0000, 32'h22);
        $display("test identifier done");
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        exp_msgs = 0;
        rd(6'h10, 32'hfee0_0000);
        $display("test second reset done");
        results();
    end
endmodule
